// [dv/adc_model.sv]
`timescale 1ns/1ps
module adc_model
(
  input  wire         clk_i,    // pixel clock
  output logic [12:0] sample_o, // converter sample
  output logic [1:0]  seg_o,    // segment code
  output logic        valid_o   // sample strobe
);
  initial
  begin
    sample_o = 13'h0000;
    seg_o = 2'h0;
    valid_o = 1'b0;
  end
  // strobe stays up so samples may run every cycle
  task send(input logic [12:0] s, input logic [1:0] g);
    sample_o <= s;
    seg_o <= g;
    valid_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // released bus shows the inverse so a stale value is never reused
  task idle;
    valid_o <= 1'b0;
    sample_o <= ~sample_o;
    @(posedge clk_i);
  endtask
endmodule

// [dv/corr_checker.sv]
`timescale 1ns/1ps
`include "gain_corr_consts.vh"
module corr_checker
(
  input wire        sys_clk_i,      // pixel clock
  input wire        rst_i,          // sync reset
  input wire [12:0] adc_sample_i,   // raw sample
  input wire [1:0]  seg_sel_i,      // segment code
  input wire        sample_valid_i, // sample strobe
  input wire        cal_done_i,     // calibration pulse
  input wire [7:0]  cal_seg4x_i,    // found 4x offset
  input wire [7:0]  reg_addr_i,     // address
  input wire [7:0]  reg_wdata_i,    // write data
  input wire        reg_wr_i,       // write strobe
  input wire        reg_rd_i,       // read strobe
  input wire [7:0]  reg_rdata_o,    // read data
  input wire        reg_rvalid_o,   // read valid
  input wire [12:0] pix_o,          // pixel
  input wire        pix_valid_o,    // pixel strobe
  input wire        pix_clip_o      // clamp flag
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // steps of a 4x offset access
  sequence s_rd4x;
    reg_rd_i && !reg_wr_i && reg_addr_i == `SEG4X_OFFSET_ADDR;
  endsequence
  sequence s_wr4x;
    reg_wr_i && !cal_done_i && reg_addr_i == `SEG4X_OFFSET_ADDR;
  endsequence
  property p_wr_rd;
    s_wr4x ##1 s_rd4x |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("readback wrong");
  property p_cal;
    cal_done_i ##1 s_rd4x |=> reg_rdata_o == $past(cal_seg4x_i, 2);
  endproperty
  a_cal: assert property (p_cal)
    else $error("cal not loaded");
  property p_rd_lat;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("no read data");
  property p_rv_quiet;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rv_quiet: assert property (p_rv_quiet)
    else $error("stray valid");
  property p_pix_lat;
    sample_valid_i |=> pix_valid_o;
  endproperty
  a_pix_lat: assert property (p_pix_lat)
    else $error("no pixel");
  property p_hold;
    !sample_valid_i |=> !pix_valid_o && $stable(pix_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pixel moved");
  property p_seg8x;
    sample_valid_i && seg_sel_i == `SEG_CODE_8X
      |=> pix_o == $past(adc_sample_i) && !pix_clip_o;
  endproperty
  a_seg8x: assert property (p_seg8x)
    else $error("8x altered");
  property p_clamp;
    pix_valid_o && pix_clip_o |-> pix_o == 13'h0000 || pix_o == `PIX_MAX;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("bad clamp");
endmodule
bind gain_segment_offset_corrector corr_checker u_chk
(
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .adc_sample_i(adc_sample_i),
  .seg_sel_i(seg_sel_i), .sample_valid_i(sample_valid_i),
  .cal_done_i(cal_done_i), .cal_seg4x_i(cal_seg4x_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .pix_o(pix_o), .pix_valid_o(pix_valid_o),
  .pix_clip_o(pix_clip_o)
);

// [dv/gain_segment_offset_corrector_tb.sv]
`timescale 1ns/1ps
module gain_segment_offset_corrector_tb;
  logic        sys_clk_i, rst_i, cal_done_i, reg_wr_i, reg_rd_i;
  logic [7:0]  cal_seg4x_i, cal_seg2x_i, cal_seg1x_i, reg_addr_i, reg_wdata_i;
  wire  [12:0] adc_sample_i, pix_o;
  wire  [1:0]  seg_sel_i;
  wire  [7:0]  reg_rdata_o;
  wire         sample_valid_i, reg_rvalid_o, pix_valid_o, pix_clip_o;
  int          errors, n_checks, seed;
  logic [7:0]  off [3];
  logic [12:0] r;
  logic [7:0]  rq [$];
  logic [13:0] pq [$];
  logic [13:0] e, exp_p;
  logic [7:0]  exp_r, stat;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  adc_model adc (.clk_i(sys_clk_i), .sample_o(adc_sample_i),
    .seg_o(seg_sel_i), .valid_o(sample_valid_i));
  gain_segment_offset_corrector dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .adc_sample_i(adc_sample_i), .seg_sel_i(seg_sel_i),
    .sample_valid_i(sample_valid_i), .cal_done_i(cal_done_i),
    .cal_seg4x_i(cal_seg4x_i), .cal_seg2x_i(cal_seg2x_i),
    .cal_seg1x_i(cal_seg1x_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pix_o(pix_o),
    .pix_valid_o(pix_valid_o), .pix_clip_o(pix_clip_o));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // clamped pixel worked out from the offsets the bench believes are held
  // clip flag on top, clamped pixel below
  function automatic logic [13:0] exp_pix(int s, int g);
    int v;
    logic c;
    c = 1'b0;
    case (g)
      0: v = s;
      1: v = 2 * s + $signed(off[0]);
      2: v = 4 * s + 2 * $signed(off[1]);
      default: v = 8 * s + 4 * $signed(off[2]);
    endcase
    if (v < 0) c = 1'b1;
    if (v > 8191) c = 1'b1;
    if (v < 0) v = 0;
    if (v > 8191) v = 8191;
    return {c, v[12:0]};
  endfunction
  // strobes stay up between back-to-back calls; bus_idle drops them
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    if (a >= 8'h10 && a <= 8'h12) off[a - 8'h10] = d;
    @(posedge sys_clk_i);
  endtask
  task rd(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    if (a == 8'h13) rq.push_back(stat);
    else if (a >= 8'h10 && a <= 8'h12) rq.push_back(off[a - 8'h10]);
    else rq.push_back(8'h00);
    if (a == 8'h13) stat[1] = 1'b0;
    @(posedge sys_clk_i);
  endtask
  task bus_idle;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // calibration load; also releases the register strobes
  task cal_load(input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] c);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    cal_seg4x_i <= a;
    cal_seg2x_i <= b;
    cal_seg1x_i <= c;
    cal_done_i <= 1'b1;
    off = '{a, b, c};
    stat[0] = 1'b1;
    @(posedge sys_clk_i);
    cal_done_i <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // results checked mid-cycle, where registered outputs have settled
  always @(negedge sys_clk_i)
  begin
    if (reg_rvalid_o === 1'b1)
    begin
      exp_r = rq.pop_front();
      `CHK(reg_rdata_o, exp_r)
    end
    if (pix_valid_o === 1'b1)
    begin
      exp_p = pq.pop_front();
      `CHK({pix_clip_o, pix_o}, exp_p)
    end
  end
  // the run needs about 120 cycles; far beyond that means a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    $display("unexpected at %0t: timeout", $time);
    give_verdict;
  end
  initial
  begin
    seed = 45;
    rst_i = 1'b1;
    cal_done_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    {cal_seg4x_i, cal_seg2x_i, cal_seg1x_i} = 24'h000000;
    off = '{default: 8'h00};
    stat = 8'h00;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) rd(8'h10 + i);
    $display("test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h10 + i, $random(seed));
      rd(8'h10 + i);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20);
    $display("test register access done");
    cal_load($random(seed), $random(seed), $random(seed));
    for (int i = 0; i < 4; i++) rd(8'h10 + i);
    bus_idle;
    $display("test calibration load done");
    for (int j = 0; j < 2; j++)
    begin
      // second pass recalibrates to extreme offsets, so seams clamp both
      // ways; the host never overwrites calibrated offsets itself
      if (j == 1) cal_load(8'h80, 8'h7F, 8'h80);
      for (int i = 0; i < 40; i++)
      begin
        r = $random(seed);
        r = r >> (i % 4);
        e = exp_pix(r, i % 4);
        stat[1] = stat[1] | e[13];
        pq.push_back(e);
        adc.send(r, i % 4);
      end
      adc.idle;
      rd(8'h13);
      bus_idle;
    end
    repeat (3) @(posedge sys_clk_i);
    `CHK(rq.size() + pq.size(), 0)
    $display("test pixel path done");
    give_verdict;
  end
endmodule

// [hdl/gain_segment_offset_corrector.v]
`timescale 1ns/1ps
`include "gain_corr_consts.vh"

// Overview of operation
// - a sample from the 8x segment leaves unchanged, no scale, no offset.
// - a 4x sample leaves doubled plus the first offset on 13 bits.
// - the first offset is 8-bit two's complement and used only for 4x.
// - the second offset is 8-bit two's complement and used only for 2x.
// - the third offset is 8-bit two's complement and used only for 1x.
// - when calibration completes, all three offsets load and stay readable.
// - the calibrated offsets keep the transfer continuous across segments.
// - the three offsets reset to zero and are readable and writable.
module gain_segment_offset_corrector
(
  input  wire        sys_clk_i,       // pixel clock, 50 MHz
  input  wire        rst_i,           // synchronous reset, active high
  // converter side, same clock domain
  input  wire [12:0] adc_sample_i,    // raw converter sample
  input  wire [1:0]  seg_sel_i,       // gain segment of the sample
  input  wire        sample_valid_i,  // sample strobe
  // internal calibration
  input  wire        cal_done_i,      // calibration complete pulse
  input  wire [7:0]  cal_seg4x_i,     // found offset for 4x
  input  wire [7:0]  cal_seg2x_i,     // found offset for 2x
  input  wire [7:0]  cal_seg1x_i,     // found offset for 1x
  // register port from the serial interface decoder
  input  wire [7:0]  reg_addr_i,      // register address
  input  wire [7:0]  reg_wdata_i,     // write data
  input  wire        reg_wr_i,        // write strobe
  input  wire        reg_rd_i,        // read strobe
  output reg  [7:0]  reg_rdata_o,     // read data
  output reg         reg_rvalid_o,    // read data valid pulse
  // downstream pixel path
  output reg  [12:0] pix_o,           // corrected pixel
  output reg         pix_valid_o,     // corrected pixel strobe
  output reg         pix_clip_o       // pixel was clamped
);

  localparam NUM_SEG = 3;
  localparam [7:0] STATUS_RST = `CORR_STATUS_RESET;

  wire [8*NUM_SEG-1:0] cal_vals_w;
  wire [8*NUM_SEG-1:0] offs_w;
  wire [7:0]           seg4x_correction;
  wire [7:0]           seg2x_correction;
  wire [7:0]           seg1x_correction;
  wire                 seg4x_correction_bit7;
  wire                 seg2x_correction_bit7;
  wire                 seg1x_correction_bit7;
  wire [12:0]          scaled_w;
  wire                 clip_w;

  reg                  cal_loaded_q;
  reg                  cal_loaded_d;
  reg                  clip_seen_q;
  reg                  clip_seen_d;
  reg  [7:0]           rdata_d;
  reg  [12:0]          pix_d;
  reg                  pix_valid_d;
  reg                  pix_clip_d;

  // calibration results, indexed like the offset registers
  assign cal_vals_w = {cal_seg1x_i, cal_seg2x_i, cal_seg4x_i};

  // one offset register per segment: index 0 is 4x, 1 is 2x, 2 is 1x
  genvar k;
  generate
    for (k = 0; k < NUM_SEG; k = k + 1)
    begin : seg_g
      localparam [7:0] ADDR = (k == 0) ? `SEG4X_OFFSET_ADDR :
                              (k == 1) ? `SEG2X_OFFSET_ADDR :
                                         `SEG1X_OFFSET_ADDR;
      reg [7:0] corr_q;
      reg [7:0] corr_d;

      // calibration load beats a host write landing in the same cycle,
      // so the found value is never lost to a racing write
      always @*
      begin
        corr_d = corr_q;
        if (cal_done_i)
        begin
          corr_d = cal_vals_w[8*k +: 8];
        end
        else if (reg_wr_i && (reg_addr_i == ADDR))
        begin
          // writes are honoured; they discard calibration
          corr_d = reg_wdata_i;
        end
      end

      always @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          corr_q <= `SEG_OFFSET_RESET;
        end
        else
        begin
          corr_q <= corr_d;
        end
      end

      assign offs_w[8*k +: 8] = corr_q;
    end
  endgenerate

  assign seg4x_correction      = offs_w[7:0];
  assign seg2x_correction      = offs_w[15:8];
  assign seg1x_correction      = offs_w[23:16];
  assign seg4x_correction_bit7 = seg4x_correction[7];
  assign seg2x_correction_bit7 = seg2x_correction[7];
  assign seg1x_correction_bit7 = seg1x_correction[7];

  // datapath: each segment sees only its own offset, which lines the
  // segments up at their boundaries
  segment_scaler u_scaler
  (
    .sample_i (adc_sample_i),
    .seg_i    (seg_sel_i),
    // sign bits travel on their own nets
    .off4x_i  ({seg4x_correction_bit7, seg4x_correction[6:0]}),
    .off2x_i  ({seg2x_correction_bit7, seg2x_correction[6:0]}),
    .off1x_i  ({seg1x_correction_bit7, seg1x_correction[6:0]}),
    .result_o (scaled_w),
    .clip_o   (clip_w)
  );

  // output stage: one register, so the pixel trails the sample by a cycle;
  // the pixel holds between strobes so downstream may sample it late
  always @*
  begin
    pix_d       = pix_o;
    pix_valid_d = sample_valid_i;
    pix_clip_d  = pix_clip_o;
    if (sample_valid_i)
    begin
      pix_d      = scaled_w;
      pix_clip_d = clip_w;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pix_o       <= 13'h0000;
      pix_valid_o <= 1'b0;
      pix_clip_o  <= 1'b0;
    end
    else
    begin
      pix_o       <= pix_d;
      pix_valid_o <= pix_valid_d;
      pix_clip_o  <= pix_clip_d;
    end
  end

  // status flags: loaded is set by calibration and stays until reset;
  // clip is sticky and cleared by reading status, with a new clip winning
  always @*
  begin
    cal_loaded_d = cal_loaded_q | cal_done_i;
    clip_seen_d  = clip_seen_q;
    if (reg_rd_i && (reg_addr_i == `CORR_STATUS_ADDR))
    begin
      clip_seen_d = 1'b0;
    end
    if (sample_valid_i && clip_w)
    begin
      clip_seen_d = 1'b1;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cal_loaded_q <= STATUS_RST[`STAT_CAL_LOADED_BIT];
      clip_seen_q  <= STATUS_RST[`STAT_CLIP_BIT];
    end
    else
    begin
      cal_loaded_q <= cal_loaded_d;
      clip_seen_q  <= clip_seen_d;
    end
  end

  // read mux; unmapped addresses read as zero
  always @*
  begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `SEG4X_OFFSET_ADDR:
      begin
        rdata_d = seg4x_correction;
      end
      `SEG2X_OFFSET_ADDR:
      begin
        rdata_d = seg2x_correction;
      end
      `SEG1X_OFFSET_ADDR:
      begin
        rdata_d = seg1x_correction;
      end
      `CORR_STATUS_ADDR:
      begin
        rdata_d[`STAT_CAL_LOADED_BIT] = cal_loaded_q;
        rdata_d[`STAT_CLIP_BIT]       = clip_seen_q;
      end
      default:
      begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // read data registered; it holds until the next read
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule

// [hdl/segment_scaler.v]
`timescale 1ns/1ps
`include "gain_corr_consts.vh"

module segment_scaler
(
  input  wire [12:0] sample_i,   // raw converter sample
  input  wire [1:0]  seg_i,      // gain segment of the sample
  input  wire [7:0]  off4x_i,    // signed offset for the 4x segment
  input  wire [7:0]  off2x_i,    // signed offset for the 2x segment
  input  wire [7:0]  off1x_i,    // signed offset for the 1x segment
  output reg  [12:0] result_o,   // corrected, clamped pixel
  output reg         clip_o      // result was clamped
);

  reg signed [17:0] samp_ext;
  reg signed [17:0] sum;

  // scale and offset per segment; arithmetic is wide so that no sum wraps
  always @*
  begin
    samp_ext = {5'h00, sample_i};
    sum      = samp_ext;
    case (seg_i)
      `SEG_CODE_8X:
      begin
        sum = samp_ext;
      end
      `SEG_CODE_4X:
      begin
        // sample doubled plus the 4x offset, sign extended
        sum = {samp_ext[16:0], 1'b0}
            + {{10{off4x_i[7]}}, off4x_i};
      end
      `SEG_CODE_2X:
      begin
        sum = {samp_ext[15:0], 2'h0}
            + {{9{off2x_i[7]}}, off2x_i, 1'b0};
      end
      `SEG_CODE_1X:
      begin
        sum = {samp_ext[14:0], 3'h0}
            + {{8{off1x_i[7]}}, off1x_i, 2'h0};
      end
      default:
      begin
        sum = samp_ext;
      end
    endcase
    // clamp to the 13-bit range rather than let the pixel wrap round
    if (sum < 18'sh00000)
    begin
      result_o = 13'h0000;
      clip_o   = 1'b1;
    end
    else if (sum > $signed({5'h00, `PIX_MAX}))
    begin
      result_o = `PIX_MAX;
      clip_o   = 1'b1;
    end
    else
    begin
      result_o = sum[12:0];
      clip_o   = 1'b0;
    end
  end

endmodule

// [pkg/gain_corr_consts.vh]
`ifndef GAIN_CORR_CONSTS_VH
`define GAIN_CORR_CONSTS_VH

// register addresses on the serial register port
`define SEG4X_OFFSET_ADDR   8'h10
`define SEG2X_OFFSET_ADDR   8'h11
// printed address of the third offset; it collides with the second
`define SEG1X_PRINTED_ADDR  8'h11
// decoded address of the third offset, where the collision is resolved
`define SEG1X_OFFSET_ADDR   8'h12
// status: calibration loaded and clip flags
`define CORR_STATUS_ADDR    8'h13

// reset values
`define SEG_OFFSET_RESET    8'h00
`define CORR_STATUS_RESET   8'h00

// status field positions
`define STAT_CAL_LOADED_BIT 0
`define STAT_CLIP_BIT       1

// gain segment codes on the segment select input
`define SEG_CODE_8X         2'h0
`define SEG_CODE_4X         2'h1
`define SEG_CODE_2X         2'h2
`define SEG_CODE_1X         2'h3

// output range of the corrected pixel
`define PIX_MAX             13'h1FFF

`endif
